/* File: logic/lea_pkg.sv */
// Constants and types for the little-endian address swizzle block.
// Assumes a 32-bit effective address with bit 0 as the least significant.
package lea_pkg;
  localparam int LEA_ADDR_W = 32;
  localparam int LEA_DATA_W = 64;
  localparam int LEA_INSN_W = 32;
  localparam int LEA_CFG_W = 32;
  // Mode bit position inside the configuration register, big-endian numbering
  localparam int LEA_MODE_BIT_BE = 28;
  localparam int LEA_MODE_BIT = LEA_CFG_W - 1 - LEA_MODE_BIT_BE;
  localparam logic [LEA_CFG_W-1:0] LEA_CFG_RESET = 32'h0000_0000;
  // Access width codes
  localparam logic [1:0] LEA_W_DWORD = 2'h3;
  localparam logic [1:0] LEA_W_WORD = 2'h2;
  localparam logic [1:0] LEA_W_HALF = 2'h1;
  localparam logic [1:0] LEA_W_BYTE = 2'h0;
  // Low-address XOR masks per width
  localparam logic [2:0] LEA_XOR_DWORD = 3'h0;
  localparam logic [2:0] LEA_XOR_WORD = 3'h4;
  localparam logic [2:0] LEA_XOR_HALF = 3'h6;
  localparam logic [2:0] LEA_XOR_BYTE = 3'h7;
  // Operation kinds
  typedef enum logic [2:0] {
    LEA_OP_SCALAR = 3'h0,
    LEA_OP_MULTI = 3'h1,
    LEA_OP_STRING = 3'h2,
    LEA_OP_CACHE = 3'h3
  } lea_op_e;
  // Exception cause codes, higher priority first
  typedef enum logic [1:0] {
    LEA_EXC_NONE = 2'h0,
    LEA_EXC_ALIGN = 2'h1,
    LEA_EXC_DACC = 2'h2
  } lea_exc_e;
endpackage : lea_pkg

/* File: logic/lea_mem_if.sv */
// Carrier between the access pipeline and the address swizzle leaf.
// Assumes one access per cycle, all signals synchronous to the core clock.
`timescale 1ns/1ps
`default_nettype none
interface lea_mem_if
  import lea_pkg::*;
();
  logic le_mode;
  logic [LEA_ADDR_W-1:0] ea;
  logic [1:0] width;
  lea_op_e op;
  logic [LEA_ADDR_W-1:0] phys;
  logic misaligned;
  modport core (output le_mode, output ea, output width, output op,
                input phys, input misaligned);
  modport swz (input le_mode, input ea, input width, input op,
               output phys, output misaligned);
endinterface : lea_mem_if
`default_nettype wire

/* File: logic/lea_addr_swz.sv */
// Combinational low-address modification and misalignment detection.
// Assumes the caller registers the results.
`timescale 1ns/1ps
`default_nettype none
module lea_addr_swz
  import lea_pkg::*;
(
  lea_mem_if.swz m
);
  logic [2:0] xor_mask;
  logic cache_op;
  logic [2:0] align_mask;
  assign cache_op = (m.op == LEA_OP_CACHE);
  // Masks double as alignment masks: width-1 low bits must be zero
  assign xor_mask = (m.width == LEA_W_DWORD) ? LEA_XOR_DWORD :
                    (m.width == LEA_W_WORD) ? LEA_XOR_WORD :
                    (m.width == LEA_W_HALF) ? LEA_XOR_HALF :
                    LEA_XOR_BYTE; // R16
  assign align_mask = ~xor_mask & LEA_XOR_BYTE;
  // Memory side stays big-endian; only the address moves
  assign m.phys = (m.le_mode && !cache_op) ?
    {m.ea[LEA_ADDR_W-1:3], m.ea[2:0] ^ xor_mask} : m.ea; // R16 R18
  assign m.misaligned = !cache_op && ((m.ea[2:0] & align_mask) != 3'h0);
endmodule : lea_addr_swz
`default_nettype wire

/* File: logic/lea_fetch_swap.sv */
// Swaps the two instruction words of a fetched doubleword.
// Assumes the doubleword arrives big-endian, first word in the high half.
`timescale 1ns/1ps
`default_nettype none
module lea_fetch_swap
  import lea_pkg::*;
(
  input wire logic i_le_mode,
  input wire logic [LEA_DATA_W-1:0] i_dword,
  output logic [LEA_DATA_W-1:0] o_dword
);
  assign o_dword = i_le_mode ?
    {i_dword[LEA_INSN_W-1:0], i_dword[LEA_DATA_W-1:LEA_INSN_W]} :
    i_dword; // R3
endmodule : lea_fetch_swap
`default_nettype wire

/* File: logic/lea_swizzle_top.sv */
// Load/store and fetch address swizzle with little-endian mode control.
// Assumes synchronous inputs from the core pipeline on i_sys_clk.
`timescale 1ns/1ps
`default_nettype none
// Function
// R1: In LE mode, multiple-word and string accesses always raise alignment.
// R2: LE alignment faults rank with alignment, ahead of data access faults.
// R3: In LE mode, swap instruction words inside each fetched doubleword.
// R4: Exceptions report the unmodified effective address in any mode.
// R5: Big-endian places the most significant byte at the lowest address.
// R6: Little-endian view puts the least significant byte lowest.
// R7: Reset leaves big-endian; LE entered only by a config write.
// R8: Byte order lives in config register bit 28.
// R9: No machine-state endian bits; config bit alone selects order.
// R10: Software brackets the mode write with three barriers each side.
// R11: Software should disable external and timer exceptions first.
// R12: Mode-switch sequence may start anywhere, not across protection.
// R13: A repeated mode-bit write must be harmless.
// R14: Some surrounding barriers may be skipped during the switch.
// R15: Software drains queues and disables translation before switching.
// R16: LE mode XORs low address bits: 8B none, 4B 100, 2B 110, 1B 111.
// R17: Modified address goes to memory with the specified width.
// R18: Memory side stays big-endian in both modes.
// R19: Outside agents see LE data at modified byte addresses.
// R20: In LE mode any misaligned load or store raises alignment.
// R21: In LE mode sequential fetch addresses are XORed with 100.
// R22: Fault address register gets the unmodified effective address.
// R23: An access with an LE alignment fault never reaches memory.
module lea_swizzle_top
  import lea_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Config register write port (move-to-special-register), read-back and mode output
  input wire logic i_cfg_we,
  input wire logic [LEA_CFG_W-1:0] i_cfg_wdata,
  output logic [LEA_CFG_W-1:0] o_cfg_rdata,
  output logic o_le_mode,
  // Data access request from the load/store unit
  input wire logic i_acc_valid,
  input wire logic i_acc_write,
  input wire logic [1:0] i_acc_width,
  input wire lea_op_e i_acc_op,
  input wire logic [LEA_ADDR_W-1:0] i_acc_ea,
  input wire logic [LEA_DATA_W-1:0] i_acc_wdata,
  input wire logic i_acc_dacc_fault,
  // Toward data cache / memory
  output logic o_mem_valid,
  output logic o_mem_write,
  output logic [1:0] o_mem_width,
  output logic [LEA_ADDR_W-1:0] o_mem_addr,
  output logic [LEA_DATA_W-1:0] o_mem_wdata,
  // Exception report
  output logic o_exc_valid,
  output lea_exc_e o_exc_cause,
  output logic [LEA_ADDR_W-1:0] o_exc_ea,
  output logic [LEA_ADDR_W-1:0] o_fault_addr,
  // Instruction fetch
  input wire logic i_fetch_valid,
  input wire logic [LEA_ADDR_W-1:0] i_fetch_ea,
  output logic [LEA_ADDR_W-1:0] o_fetch_addr,
  input wire logic i_fetch_data_valid,
  input wire logic [LEA_DATA_W-1:0] i_fetch_data,
  output logic o_iq_valid,
  output logic [LEA_DATA_W-1:0] o_iq_data
);
  // Only the mode bit is implemented; other config bits read zero.
  // No machine-state endian bits exist anywhere in this block.
  logic [LEA_CFG_W-1:0] cfg; // R9
  logic le_mode;
  logic next_le_mode;
  lea_mem_if m();
  logic le_nonscalar;
  logic le_misalign;
  logic align_exc;
  logic dacc_exc;
  logic exc_any;
  lea_exc_e next_cause;
  logic mem_go;
  logic [LEA_DATA_W-1:0] swapped;

  // A rewrite of the same value changes nothing, so a doubled write is safe
  assign next_le_mode = i_cfg_we ? i_cfg_wdata[LEA_MODE_BIT] : le_mode; // R13

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      le_mode <= LEA_CFG_RESET[LEA_MODE_BIT]; // R7
    end else begin
      // Takes effect on the very next access, so skipped barriers are harmless
      le_mode <= next_le_mode; // R8 R14
    end
  end

  always_comb begin
    cfg = '0;
    cfg[LEA_MODE_BIT] = le_mode; // R8
  end
  assign o_cfg_rdata = cfg;
  assign o_le_mode = le_mode;

  assign m.le_mode = le_mode;
  assign m.ea = i_acc_ea;
  assign m.width = i_acc_width;
  assign m.op = i_acc_op;

  lea_addr_swz u_swz (
    .m(m.swz)
  );

  // Non-scalar moves cannot follow the modified addresses at all
  assign le_nonscalar = le_mode &&
    (i_acc_op == LEA_OP_MULTI || i_acc_op == LEA_OP_STRING); // R1
  // Big-endian mode handles misalignment elsewhere, so only LE flags it here
  assign le_misalign = le_mode && m.misaligned; // R20
  assign align_exc = i_acc_valid && (le_nonscalar || le_misalign);
  assign dacc_exc = i_acc_valid && i_acc_dacc_fault;
  assign exc_any = align_exc || dacc_exc;
  assign next_cause = align_exc ? LEA_EXC_ALIGN :
                      dacc_exc ? LEA_EXC_DACC : LEA_EXC_NONE; // R2
  // Faulting accesses are dropped before the cache sees them
  assign mem_go = i_acc_valid && !exc_any; // R23

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_mem_valid <= 1'b0;
      o_mem_write <= 1'b0;
      o_mem_width <= LEA_W_BYTE;
      o_mem_addr <= '0;
      o_mem_wdata <= '0;
    end else begin
      o_mem_valid <= mem_go; // R23
      o_mem_write <= i_acc_write;
      o_mem_width <= i_acc_width; // R17
      o_mem_addr <= m.phys; // R17 R5 R6
      o_mem_wdata <= i_acc_wdata; // R18
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_exc_valid <= 1'b0;
      o_exc_cause <= LEA_EXC_NONE;
      o_exc_ea <= '0;
      o_fault_addr <= '0;
    end else begin
      o_exc_valid <= exc_any;
      o_exc_cause <= next_cause; // R2
      if (exc_any) begin
        o_exc_ea <= i_acc_ea; // R4
      end
      if (dacc_exc && !align_exc) begin
        o_fault_addr <= i_acc_ea; // R22
      end
    end
  end

  // Fetch address: word-length rule
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_fetch_addr <= '0;
    end else if (i_fetch_valid) begin
      o_fetch_addr <= le_mode ?
        {i_fetch_ea[LEA_ADDR_W-1:3], i_fetch_ea[2:0] ^ LEA_XOR_WORD} :
        i_fetch_ea; // R21
    end
  end

  lea_fetch_swap u_fswap (
    .i_le_mode(le_mode),
    .i_dword(i_fetch_data),
    .o_dword(swapped)
  );

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_iq_valid <= 1'b0;
      o_iq_data <= '0;
    end else begin
      o_iq_valid <= i_fetch_data_valid;
      o_iq_data <= swapped; // R3
    end
  end
endmodule : lea_swizzle_top
`default_nettype wire

/* File: tb/lea_mem_model.sv */
// Byte store behind the swizzle, kept in big-endian byte order.
// Assumes store data sits in the low bytes of the data word.
`timescale 1ns/1ps
`default_nettype none
module lea_mem_model
  import lea_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_valid,
  input wire logic i_write,
  input wire logic [1:0] i_width,
  input wire logic [LEA_ADDR_W-1:0] i_addr,
  input wire logic [LEA_DATA_W-1:0] i_wdata
);
  // Only 256 bytes kept; upper address bits alias
  logic [7:0] mem [256];
  int n;
  always @(posedge i_clk) begin
    n = 1 << i_width;
    for (int i = 0; i < n; i++) begin
      if (i_valid && i_write) begin
        mem[i_addr[7:0] + 8'(i)] <= i_wdata[8 * (n - 1 - i) +: 8];
      end
    end
  end
endmodule : lea_mem_model
`default_nettype wire

/* File: tb/lea_swz_monitor.sv */
// Port checker for the swizzle top.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module lea_swz_monitor
  import lea_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_cfg_we,
  input wire logic [LEA_CFG_W-1:0] i_cfg_wdata,
  input wire logic o_le_mode,
  input wire logic i_acc_valid,
  input wire logic [1:0] i_acc_width,
  input wire lea_op_e i_acc_op,
  input wire logic [LEA_ADDR_W-1:0] i_acc_ea,
  input wire logic i_acc_dacc_fault,
  input wire logic o_mem_valid,
  input wire logic [LEA_ADDR_W-1:0] o_mem_addr,
  input wire logic o_exc_valid,
  input wire lea_exc_e o_exc_cause,
  input wire logic [LEA_ADDR_W-1:0] o_exc_ea
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  wire logic le_acc = i_acc_valid && o_le_mode;
  rst_mode_a:
    assert property ($rose(i_rst_n) |-> !o_le_mode && !o_mem_valid)
    else $error("mode or access set after reset");
  mode_load_a:
    assert property (i_cfg_we |=> o_le_mode == $past(i_cfg_wdata[LEA_MODE_BIT]))
    else $error("mode bit not loaded");
  mode_hold_a:
    assert property (!i_cfg_we |=> $stable(o_le_mode))
    else $error("mode changed without write");
  multi_exc_a:
    assert property (le_acc && i_acc_op inside {LEA_OP_MULTI, LEA_OP_STRING}
      |=> o_exc_valid && o_exc_cause == LEA_EXC_ALIGN && !o_mem_valid)
    else $error("multiple or string access not refused");
  byte_xor_a:
    assert property (le_acc && i_acc_op == LEA_OP_SCALAR && !i_acc_dacc_fault
      && i_acc_width == LEA_W_BYTE |=> o_mem_valid
      && o_mem_addr == ($past(i_acc_ea) ^ 32'h7))
    else $error("byte address not modified");
  half_mis_a:
    assert property (le_acc && i_acc_op == LEA_OP_SCALAR && i_acc_ea[0]
      && i_acc_width == LEA_W_HALF |=> o_exc_cause == LEA_EXC_ALIGN)
    else $error("misaligned half not refused");
  be_pass_a:
    assert property (i_acc_valid && !o_le_mode && !i_acc_dacc_fault
      |=> o_mem_valid && o_mem_addr == $past(i_acc_ea))
    else $error("big-endian address altered");
  exc_ea_a:
    assert property (o_exc_valid |-> o_exc_ea == $past(i_acc_ea))
    else $error("exception address modified");
endmodule : lea_swz_monitor
bind lea_swizzle_top lea_swz_monitor lea_swz_monitor_inst (.*);
`default_nettype wire

/* File: tb/tb_top.sv */
// Random and corner-case bench for the swizzle top with a store model.
// Assumes outputs register one cycle after each request.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import lea_pkg::*;
  logic i_sys_clk = 0, i_rst_n = 0, i_cfg_we = 0, i_acc_valid = 0;
  logic i_acc_write = 0, i_acc_dacc_fault = 0, i_fetch_valid = 0;
  logic i_fetch_data_valid = 0, o_le_mode, o_mem_valid, o_mem_write;
  logic o_exc_valid, o_iq_valid;
  logic [1:0] i_acc_width = 0, o_mem_width;
  lea_op_e i_acc_op = LEA_OP_SCALAR;
  lea_exc_e o_exc_cause;
  logic [31:0] i_cfg_wdata = 0, i_acc_ea = 0, i_fetch_ea = 0, o_cfg_rdata;
  logic [31:0] o_mem_addr, o_exc_ea, o_fault_addr, o_fetch_addr;
  logic [63:0] i_acc_wdata = 0, i_fetch_data = 0, o_mem_wdata, o_iq_data;
  int n_mismatch = 0, n_tests = 0, cyc = 0;
  logic [31:0] last_exc = 0, last_fault = 0;
  lea_swizzle_top lea_swizzle_top_inst (.*);
  lea_mem_model lea_mem_model_inst (.i_clk(i_sys_clk), .i_valid(o_mem_valid),
    .i_write(o_mem_write), .i_width(o_mem_width), .i_addr(o_mem_addr),
    .i_wdata(o_mem_wdata));
  initial forever #4 i_sys_clk = ~i_sys_clk;
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    n_tests++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic finish_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test
  // Mode switch with no access up; an idle cycle follows the write
  task automatic cfg(input logic m);
    i_acc_valid = 0;
    i_cfg_we = 1;
    i_cfg_wdata = {28'h0, m, 3'h0};
    @(posedge i_sys_clk);
    #1 i_cfg_we = 0;
    chk(o_le_mode, m);
    chk(o_cfg_rdata, {28'h0, m, 3'h0});
    @(posedge i_sys_clk);
    #1;
  endtask : cfg
  // Leaves the request up so back-to-back accesses stay legal
  task automatic acc(lea_op_e op, logic [1:0] w, logic [31:0] ea, logic f);
    logic le;
    lea_exc_e c;
    le = o_le_mode;
    c = (le && (op inside {LEA_OP_MULTI, LEA_OP_STRING} || op == LEA_OP_SCALAR
      && (ea & ((32'h1 << w) - 1)) != 0)) ? LEA_EXC_ALIGN
      : f ? LEA_EXC_DACC : LEA_EXC_NONE;
    if (c != LEA_EXC_NONE) last_exc = ea;
    if (c == LEA_EXC_DACC) last_fault = ea;
    {i_acc_valid, i_acc_op, i_acc_width, i_acc_ea} = {1'b1, op, w, ea};
    i_acc_dacc_fault = f;
    @(posedge i_sys_clk);
    #1 chk(o_mem_valid, c == LEA_EXC_NONE);
    chk(o_exc_valid, c != LEA_EXC_NONE);
    if (c == LEA_EXC_NONE) chk(o_mem_addr, (le && op != LEA_OP_CACHE) ?
      ea ^ {29'h0, 3'(3'h7 << w)} : ea);
    else chk({o_exc_cause, o_exc_ea}, {c, ea});
    chk({o_mem_write, o_mem_width}, {i_acc_write, w});
    chk(o_mem_wdata, i_acc_wdata);
    chk(o_exc_ea, last_exc);
    chk(o_fault_addr, last_fault);
  endtask : acc
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 6000) begin
      n_mismatch++;
      finish_test;
    end
  end
  initial begin
    void'($urandom(3));
    repeat (5) @(posedge i_sys_clk);
    #1 i_rst_n = 1;
    chk(o_le_mode, 0);
    cfg(1);
    cfg(1);
    acc(LEA_OP_SCALAR, LEA_W_BYTE, 32'h5, 0);
    for (int k = 0; k < 4; k++) acc(lea_op_e'(k), LEA_W_WORD, 32'h8, 1);
    repeat (400) begin
      if ($urandom_range(0, 20) == 0) cfg(1'($urandom_range(0, 1)));
      i_acc_write = 1'($urandom);
      i_acc_wdata = {$urandom, $urandom};
      acc(lea_op_e'($urandom_range(0, 3)), 2'($urandom), $urandom,
        $urandom % 8 == 0);
    end
    cfg(1);
    // Mid-run reset from little-endian mode must come back big-endian
    i_rst_n = 0;
    repeat (2) @(posedge i_sys_clk);
    #1 i_rst_n = 1;
    last_exc = 0;
    last_fault = 0;
    chk({o_le_mode, o_mem_valid, o_exc_valid, o_iq_valid}, 4'h0);
    chk({o_exc_ea, o_fault_addr}, 64'h0);
    i_fetch_valid = 1;
    i_fetch_data_valid = 1;
    i_fetch_ea = 32'h20;
    i_fetch_data = 64'h0123_4567_89AB_CDEF;
    @(posedge i_sys_clk);
    #1 chk(o_fetch_addr, 32'h20);
    chk(o_iq_data, 64'h0123_4567_89AB_CDEF);
    cfg(1);
    i_acc_write = 1;
    i_acc_wdata = 64'h1112_1314;
    acc(LEA_OP_SCALAR, LEA_W_WORD, 32'h10, 0);
    i_acc_valid = 0;
    i_fetch_valid = 1;
    i_fetch_data_valid = 1;
    i_fetch_ea = 32'h20;
    i_fetch_data = 64'h0123_4567_89AB_CDEF;
    @(posedge i_sys_clk);
    #1 chk(o_fetch_addr, 32'h24);
    chk({o_iq_valid, o_iq_data}, {1'b1, 64'h89AB_CDEF_0123_4567});
    chk({lea_mem_model_inst.mem[20], lea_mem_model_inst.mem[21],
      lea_mem_model_inst.mem[22], lea_mem_model_inst.mem[23]},
      32'h1112_1314);
    finish_test;
  end
endmodule : tb_top
`default_nettype wire
